// ===== design/vip_pkg.sv
// constants for the vectored interrupt prioritizer
package vip_pkg;
    localparam int VIP_NSRC = 64;
    localparam int VIP_NVEC = 44;
    localparam int VIP_NPIN = 5;
    localparam int VIP_VEC_W = 6;
    localparam int VIP_KEY_W = 5;
    localparam int VIP_HALF = 32;
    localparam int VIP_BYTE_W = 8;
    localparam int VIP_VEC_PER_WORD = 4;
    // register offsets
    localparam logic [7:0] VIP_OFF_FLAGS_LO = 8'h00;
    localparam logic [7:0] VIP_OFF_FLAGS_HI = 8'h04;
    localparam logic [7:0] VIP_OFF_EN_LO = 8'h08;
    localparam logic [7:0] VIP_OFF_EN_HI = 8'h0C;
    localparam logic [7:0] VIP_OFF_PRIO_FIRST = 8'h10;
    localparam logic [7:0] VIP_OFF_PRIO_LAST = 8'h38;
    localparam logic [7:0] VIP_OFF_CTRL = 8'h40;
    localparam logic [7:0] VIP_OFF_STATUS = 8'h44;
    localparam logic [7:0] VIP_OFF_TBL_BASE = 8'h48;
    localparam logic [7:0] VIP_OFF_TBL_SPACE = 8'h4C;
    localparam logic [7:0] VIP_OFF_TARGET = 8'h50;
    localparam logic [7:0] VIP_WORD_STEP = 8'h04;
    // field layout
    localparam int VIP_CTRL_MVEC_BIT = 0;
    localparam int VIP_CTRL_POL_LSB = 1;
    localparam int VIP_SPACE_W = 10;
    localparam logic [31:0] VIP_RST_WORD = 32'h0000_0000;
    localparam logic [31:0] VIP_RST_BASE = 32'h0000_0000;
    localparam logic [VIP_SPACE_W-1:0] VIP_RST_SPACE = 10'h020;
    // source to vector map
    localparam logic [5:0] VIP_SRC_VEC [VIP_NSRC] = '{
        6'h00, 6'h01, 6'h02, 6'h03, 6'h04, 6'h05, 6'h05, 6'h06,
        6'h07, 6'h08, 6'h09, 6'h09, 6'h0A, 6'h0B, 6'h0C, 6'h0D,
        6'h0D, 6'h0E, 6'h0F, 6'h10, 6'h11, 6'h11, 6'h12, 6'h13,
        6'h14, 6'h15, 6'h15, 6'h16, 6'h17, 6'h18, 6'h19, 6'h1A,
        6'h1B, 6'h1C, 6'h1D, 6'h1E, 6'h1F, 6'h1F, 6'h1F, 6'h20,
        6'h20, 6'h20, 6'h21, 6'h21, 6'h21, 6'h22, 6'h22, 6'h22,
        6'h23, 6'h23, 6'h24, 6'h24, 6'h24, 6'h25, 6'h25, 6'h25,
        6'h26, 6'h26, 6'h26, 6'h27, 6'h28, 6'h29, 6'h2A, 6'h2B};
    localparam logic [VIP_NSRC-1:0] VIP_PERSIST = 64'h0FFF_FFF8_1631_8C60;
    localparam int VIP_PIN_SRC [VIP_NPIN] = '{3, 8, 13, 18, 23};
    localparam int VIP_SRC_CORE_TICK = 0;
    localparam int VIP_SRC_CONV_DONE = 28;
endpackage

// ===== design/vip_pin_edge.sv
// pin synchroniser with edge polarity select
`timescale 1ns/10ps
module vip_pin_edge
    import vip_pkg::*;
(
    // clock and reset
    input wire logic mclk_i,
    input wire logic rst_n_i,
    // pin and polarity
    input wire logic pin_i,
    input wire logic rising_i,
    // detected edge
    output logic edge_o
);
    logic meta_reg;
    logic sync_reg;
    logic prev_reg;

    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            meta_reg <= 1'b0;
            sync_reg <= 1'b0;
            prev_reg <= 1'b0;
        end
        else
        begin
            meta_reg <= pin_i;
            sync_reg <= meta_reg;
            prev_reg <= sync_reg;
        end
    end

    assign edge_o = rising_i ? (sync_reg & ~prev_reg) : (~sync_reg & prev_reg);
endmodule

// ===== design/vip_arbiter.sv
// combinational winner pick over pending vectors
`timescale 1ns/10ps
module vip_arbiter
    import vip_pkg::*;
#(
    parameter int NVEC = VIP_NVEC
)
(
    // pending vectors and their keys
    input wire logic [NVEC-1:0] pend_i,
    input wire logic [NVEC*VIP_KEY_W-1:0] key_i,
    // winner
    output logic found_o,
    output logic [VIP_VEC_W-1:0] vec_o,
    output logic [VIP_KEY_W-1:0] key_o
);
    always_comb
    begin
        found_o = 1'b0;
        vec_o = '0;
        key_o = '0;
        // downward scan, lower vector wins ties
        for (int v = NVEC - 1; v >= 0; v--)
        begin
            if (pend_i[v] && key_i[v*VIP_KEY_W+2 +: 3] != 3'h0
                && key_i[v*VIP_KEY_W +: VIP_KEY_W] >= key_o)
            begin
                found_o = 1'b1;
                vec_o = VIP_VEC_W'(v);
                key_o = key_i[v*VIP_KEY_W +: VIP_KEY_W];
            end
        end
    end
endmodule

// ===== design/vip_top.sv
// vectored interrupt prioritizer top
`timescale 1ns/10ps
module vip_top
    import vip_pkg::*;
#(
    parameter int NSRC = VIP_NSRC,
    parameter int NVEC = VIP_NVEC
)
(
    // clock and reset
    input wire logic mclk_i,
    input wire logic rst_n_i,
    // register port
    input wire logic [7:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [31:0] rdata_o,
    // request sources and pins
    input wire logic [NSRC-1:0] src_req_i,
    input wire logic [VIP_NPIN-1:0] pin_i,
    // processor side
    output logic irq_req_o,
    output logic [VIP_VEC_W-1:0] irq_vec_o,
    output logic [2:0] irq_prio_o,
    output logic [1:0] irq_sub_o,
    output logic [31:0] irq_addr_o
);
    // ------------------------------------------------
    // state
    // ------------------------------------------------
    // one flag per source
    logic [NSRC-1:0] flags_reg;
    logic [NSRC-1:0] en_reg;
    logic [NSRC-1:0] src_prev_reg;
    logic [VIP_KEY_W-1:0] vcfg_reg [NVEC];
    logic [31:0] ctrl_reg;
    logic [31:0] base_reg;
    logic [VIP_SPACE_W-1:0] space_reg;
    logic [NSRC-1:0] hw_set;
    logic [VIP_NPIN-1:0] pin_edge;
    logic [NVEC-1:0] pend_vec;
    logic [NVEC*VIP_KEY_W-1:0] key_flat;
    logic win_found;
    logic [VIP_VEC_W-1:0] win_vec;
    logic [VIP_KEY_W-1:0] win_key;
    logic [VIP_VEC_W-1:0] out_vec_next;
    logic [31:0] rd_next;
    logic mvec;

    assign mvec = ctrl_reg[VIP_CTRL_MVEC_BIT];

    // ------------------------------------------------
    // pin edge detectors
    // ------------------------------------------------
    for (genvar p = 0; p < VIP_NPIN; p++)
    begin : g_pin
        vip_pin_edge u_edge (
            .mclk_i(mclk_i),
            .rst_n_i(rst_n_i),
            .pin_i(pin_i[p]),
            .rising_i(ctrl_reg[VIP_CTRL_POL_LSB+p]),
            .edge_o(pin_edge[p])
        );
    end

    // ------------------------------------------------
    // hardware flag sets
    // ------------------------------------------------
    always_comb
    begin
        // persistent sources are levels, others edges
        for (int s = 0; s < NSRC; s++)
        begin
            hw_set[s] = VIP_PERSIST[s] ? src_req_i[s] : (src_req_i[s] & ~src_prev_reg[s]);
        end
        for (int p = 0; p < VIP_NPIN; p++)
        begin
            hw_set[VIP_PIN_SRC[p]] = pin_edge[p];
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            src_prev_reg <= '0;
        else
            src_prev_reg <= src_req_i;
    end

    // ------------------------------------------------
    // flags and enables
    // ------------------------------------------------
    // low and high halves; written value, set wins
    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            flags_reg <= '0;
        else if (wr_i && addr_i == VIP_OFF_FLAGS_LO)
            flags_reg <= {flags_reg[NSRC-1:VIP_HALF], wdata_i} | hw_set;
        else if (wr_i && addr_i == VIP_OFF_FLAGS_HI)
            flags_reg <= {wdata_i, flags_reg[VIP_HALF-1:0]} | hw_set;
        else
            flags_reg <= flags_reg | hw_set;
    end

    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            en_reg <= '0;
        else if (wr_i && addr_i == VIP_OFF_EN_LO)
            en_reg[VIP_HALF-1:0] <= wdata_i;
        else if (wr_i && addr_i == VIP_OFF_EN_HI)
            en_reg[NSRC-1:VIP_HALF] <= wdata_i;
    end

    // ------------------------------------------------
    // per-vector priority fields
    // ------------------------------------------------
    // four vectors per word, one per byte; 3+2 bits
    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            for (int v = 0; v < NVEC; v++)
                vcfg_reg[v] <= '0;
        end
        else if (wr_i)
        begin
            for (int v = 0; v < NVEC; v++)
            begin
                if (addr_i == 8'(VIP_OFF_PRIO_FIRST + VIP_WORD_STEP * (v / VIP_VEC_PER_WORD)))
                    vcfg_reg[v] <= wdata_i[(v % VIP_VEC_PER_WORD)*VIP_BYTE_W +: VIP_KEY_W];
            end
        end
    end

    // ------------------------------------------------
    // control and vector table
    // ------------------------------------------------
    // mode bit; polarity bits; base and spacing
    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            ctrl_reg <= VIP_RST_WORD;
            base_reg <= VIP_RST_BASE;
            space_reg <= VIP_RST_SPACE;
        end
        else if (wr_i)
        begin
            if (addr_i == VIP_OFF_CTRL)
                ctrl_reg <= wdata_i & 32'h0000_003F;
            if (addr_i == VIP_OFF_TBL_BASE)
                base_reg <= wdata_i;
            if (addr_i == VIP_OFF_TBL_SPACE)
                space_reg <= wdata_i[VIP_SPACE_W-1:0];
        end
    end

    // ------------------------------------------------
    // ranking
    // ------------------------------------------------
    // fixed map folds sources into vectors
    always_comb
    begin
        pend_vec = '0;
        for (int s = 0; s < NSRC; s++)
        begin
            if (flags_reg[s] && en_reg[s])
                pend_vec[VIP_SRC_VEC[s]] = 1'b1;
        end
        for (int v = 0; v < NVEC; v++)
            key_flat[v*VIP_KEY_W +: VIP_KEY_W] = vcfg_reg[v];
    end

    // rank first, registered hand-off to the core
    vip_arbiter #(
        .NVEC(NVEC)
    ) u_arb (
        .pend_i(pend_vec),
        .key_i(key_flat),
        .found_o(win_found),
        .vec_o(win_vec),
        .key_o(win_key)
    );

    // single mode sends every request through vector zero
    assign out_vec_next = mvec ? win_vec : '0;

    // winner vector and priority to the core
    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            irq_req_o <= 1'b0;
            irq_vec_o <= '0;
            irq_prio_o <= '0;
            irq_sub_o <= '0;
            irq_addr_o <= '0;
        end
        else
        begin
            irq_req_o <= win_found;
            irq_vec_o <= out_vec_next;
            irq_prio_o <= win_key[4:2];
            irq_sub_o <= win_key[1:0];
            // entry address from base and spacing
            irq_addr_o <= base_reg + 32'(out_vec_next) * 32'(space_reg);
        end
    end

    // ------------------------------------------------
    // read port
    // ------------------------------------------------
    always_comb
    begin
        rd_next = '0;
        case (addr_i)
            VIP_OFF_FLAGS_LO: rd_next = flags_reg[VIP_HALF-1:0];
            VIP_OFF_FLAGS_HI: rd_next = flags_reg[NSRC-1:VIP_HALF];
            VIP_OFF_EN_LO: rd_next = en_reg[VIP_HALF-1:0];
            VIP_OFF_EN_HI: rd_next = en_reg[NSRC-1:VIP_HALF];
            VIP_OFF_CTRL: rd_next = ctrl_reg;
            VIP_OFF_STATUS: rd_next = {19'h0, irq_prio_o, irq_sub_o, irq_vec_o, 1'b0, irq_req_o};
            VIP_OFF_TBL_BASE: rd_next = base_reg;
            VIP_OFF_TBL_SPACE: rd_next = 32'(space_reg);
            VIP_OFF_TARGET: rd_next = irq_addr_o;
            default:
            begin
                for (int v = 0; v < NVEC; v++)
                begin
                    if (addr_i == 8'(VIP_OFF_PRIO_FIRST + VIP_WORD_STEP * (v / VIP_VEC_PER_WORD)))
                        rd_next[(v % VIP_VEC_PER_WORD)*VIP_BYTE_W +: VIP_KEY_W] = vcfg_reg[v];
                end
            end
        endcase
    end

    // data stands only in the cycle after the strobe
    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            rdata_o <= '0;
        else
            rdata_o <= rd_i ? rd_next : 32'h0000_0000;
    end

    // ------------------------------------------------
    // assertions
    // ------------------------------------------------
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);

    property p_req_prio;
        irq_req_o |-> irq_prio_o != 3'h0;
    endproperty
    a_req_prio: assert property (p_req_prio)
        else $error("request with zero priority");

    property p_found_forward;
        win_found |=> irq_req_o && irq_prio_o == $past(win_key[4:2]);
    endproperty
    a_found_forward: assert property (p_found_forward)
        else $error("winner not forwarded next cycle");

    property p_single_vec;
        irq_req_o && !$past(mvec) |-> irq_vec_o == '0;
    endproperty
    a_single_vec: assert property (p_single_vec)
        else $error("single mode vector not zero");

    property p_vec_range;
        irq_req_o |-> irq_vec_o < VIP_VEC_W'(NVEC);
    endproperty
    a_vec_range: assert property (p_vec_range)
        else $error("vector out of range");

    property p_sw_set;
        wr_i && addr_i == VIP_OFF_FLAGS_LO && wdata_i[VIP_SRC_CORE_TICK]
            |=> flags_reg[VIP_SRC_CORE_TICK];
    endproperty
    a_sw_set: assert property (p_sw_set)
        else $error("software flag write lost");

    property p_persist;
        src_req_i[VIP_SRC_CONV_DONE] |=> flags_reg[VIP_SRC_CONV_DONE];
    endproperty
    a_persist: assert property (p_persist)
        else $error("persistent level did not set flag");

    property p_pin_rise;
        ctrl_reg[VIP_CTRL_POL_LSB] && !pin_i[0] ##1 pin_i[0] [*3]
            |-> ##[1:2] flags_reg[VIP_PIN_SRC[0]];
    endproperty
    a_pin_rise: assert property (p_pin_rise)
        else $error("pin edge did not set flag");

    property p_tick_gate;
        irq_req_o && irq_vec_o == '0 && $past(mvec)
            |-> $past(flags_reg[VIP_SRC_CORE_TICK] && en_reg[VIP_SRC_CORE_TICK]);
    endproperty
    a_tick_gate: assert property (p_tick_gate)
        else $error("vector zero without flagged enabled tick");

    c_multi: cover property (irq_req_o && mvec && irq_vec_o == VIP_VEC_W'(NVEC - 1));
    c_shared: cover property (flags_reg[36] && flags_reg[38] && irq_vec_o == 6'h1F);
    c_read: cover property (rd_i ##1 rdata_o != 32'h0000_0000);
endmodule

// ===== dv/vip_core_model.sv
// processor core model that takes the prioritized request
`timescale 1ns/10ps
module vip_core_model
    import vip_pkg::*;
(
    // clock and reset
    input wire logic mclk_i,
    input wire logic rst_n_i,
    // offered request
    input wire logic irq_req_i,
    input wire logic [VIP_VEC_W-1:0] irq_vec_i,
    // taken request
    output logic taken_o,
    output logic [VIP_VEC_W-1:0] taken_vec_o
);
    // ------------------------------
    // request intake
    // ------------------------------
    // take offered winner
    // samples every cycle, so a request offered for only one cycle is still taken for one cycle
    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            taken_o <= 1'b0;
            taken_vec_o <= '0;
        end
        else
        begin
            taken_o <= irq_req_i;
            taken_vec_o <= irq_vec_i;
        end
    end
endmodule

// ===== dv/vip_top_bench.sv
// self-checking bench for the vectored interrupt prioritizer
`timescale 1ns/10ps
module vip_top_bench;
    import vip_pkg::*;
    // ------------------------------
    // signals and instances
    // ------------------------------
    logic mclk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [7:0] addr_i = 8'h00;
    logic [31:0] wdata_i = 32'h0;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic [63:0] src_req_i = 64'h0;
    logic [4:0] pin_i = 5'h1F;
    logic [31:0] rdata_o;
    logic [31:0] irq_addr_o;
    logic irq_req_o;
    logic taken;
    logic [5:0] irq_vec_o;
    logic [5:0] taken_vec;
    logic [2:0] irq_prio_o;
    logic [1:0] irq_sub_o;
    int err_count = 0;
    int n_tests = 0;
    int cyc = 0;
    integer seed = 32'hbbf8;
    logic [31:0] fl [2];
    logic [31:0] en [2];
    logic [31:0] pw [11];
    localparam int MAPS [12][2] = '{'{1, 1}, '{2, 2}, '{5, 5}, '{6, 5}, '{28, 23}, '{36, 31},
        '{37, 31}, '{38, 31}, '{60, 40}, '{61, 41}, '{62, 42}, '{63, 43}};
    localparam int PIN_VEC [5] = '{3, 7, 11, 15, 19};

    always #20 mclk_i = ~mclk_i;

    vip_top i_dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .src_req_i(src_req_i), .pin_i(pin_i),
        .irq_req_o(irq_req_o), .irq_vec_o(irq_vec_o), .irq_prio_o(irq_prio_o),
        .irq_sub_o(irq_sub_o), .irq_addr_o(irq_addr_o));

    vip_core_model i_core (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .irq_req_i(irq_req_o),
        .irq_vec_i(irq_vec_o), .taken_o(taken), .taken_vec_o(taken_vec));

    // ------------------------------
    // tasks and expectations
    // ------------------------------
    task automatic complete_run();
        if (err_count == 0 && n_tests > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // hang guard, well above the few thousand cycles the run needs
    always @(posedge mclk_i)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            err_count++;
            complete_run();
        end
    end

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic step();
        @(posedge mclk_i);
        #1;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge mclk_i);
        wr_i <= 1'b0;
    endtask

    task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
        @(posedge mclk_i);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge mclk_i);
        rd_i <= 1'b0;
        #1;
        chk(what, rdata_o, exp);
    endtask

    // flags last, so stray pin edges during setup are wiped
    task automatic load(input logic [31:0] ctrl);
        wr(VIP_OFF_CTRL, ctrl);
        for (int k = 0; k < 11; k++)
            wr(VIP_OFF_PRIO_FIRST + VIP_WORD_STEP * 8'(k), pw[k]);
        wr(VIP_OFF_EN_LO, en[0]);
        wr(VIP_OFF_EN_HI, en[1]);
        wr(VIP_OFF_FLAGS_LO, fl[0]);
        wr(VIP_OFF_FLAGS_HI, fl[1]);
        repeat (3) step();
    endtask

    // strict compare in ascending order keeps the lowest vector on ties
    function automatic logic [11:0] expect_win();
        logic [4:0] key;
        logic [4:0] best;
        logic [5:0] bv;
        logic hit;
        best = 5'h00;
        bv = 6'h00;
        hit = 1'b0;
        for (int v = 0; v < VIP_NVEC; v++)
        begin
            key = pw[v / 4][8 * (v % 4) +: 5];
            for (int s = 0; s < VIP_NSRC; s++)
                if (VIP_SRC_VEC[s] == 6'(v) && fl[s / 32][s % 32] && en[s / 32][s % 32]
                    && key[4:2] != 3'h0 && (!hit || key > best))
                begin
                    hit = 1'b1;
                    best = key;
                    bv = 6'(v);
                end
        end
        return {hit, bv, best};
    endfunction

    task automatic chk_win(input logic mv, input logic [31:0] base, input logic [31:0] sp);
        logic [11:0] w;
        logic [5:0] v;
        w = expect_win();
        v = mv ? w[10:5] : 6'h00;
        chk("irq_req", 32'(irq_req_o), 32'(w[11]));
        if (w[11])
        begin
            chk("irq_vec", 32'(irq_vec_o), 32'(v));
            chk("irq_key", 32'({irq_prio_o, irq_sub_o}), 32'(w[4:0]));
            chk("irq_addr", irq_addr_o, base + 32'(v) * sp);
            rdchk("status", VIP_OFF_STATUS, {19'h0, w[4:0], v, 1'b0, 1'b1});
        end
    endtask

    // ------------------------------
    // main sequence
    // ------------------------------
    initial
    begin
        logic [31:0] base;
        logic [31:0] sp;
        logic m;
        repeat (10) @(posedge mclk_i);
        rst_n_i <= 1'b1;
        rdchk("flags_lo", VIP_OFF_FLAGS_LO, 32'h0);
        rdchk("prio_last", VIP_OFF_PRIO_LAST, 32'h0);
        rdchk("spacing", VIP_OFF_TBL_SPACE, 32'h0000_0020);
        wr(8'h60, 32'hFFFF_FFFF);
        rdchk("unmapped", 8'h60, 32'h0);
        wr(VIP_OFF_PRIO_FIRST, 32'hFFFF_FFFF);
        rdchk("prio_mask", VIP_OFF_PRIO_FIRST, 32'h1F1F_1F1F);
        wr(VIP_OFF_EN_HI, 32'h8000_0001);
        rdchk("en_hi", VIP_OFF_EN_HI, 32'h8000_0001);
        // software flag per source, shared vectors
        en = '{32'hFFFF_FFFF, 32'hFFFF_FFFF};
        for (int k = 0; k < 11; k++)
            pw[k] = 32'h0404_0404;
        for (int i = 0; i < 12; i++)
        begin
            fl = '{32'h0, 32'h0};
            fl[MAPS[i][0] / 32][MAPS[i][0] % 32] = 1'b1;
            load(32'h1);
            chk("map_vec", 32'(irq_vec_o), 32'(MAPS[i][1]));
        end
        // core tick edge, then service clears it
        fl = '{32'h0, 32'h0};
        pw[0] = 32'h0404_0409;
        load(32'h1);
        @(posedge mclk_i);
        src_req_i[0] <= 1'b1;
        for (int t = 0; t < 8 && irq_req_o !== 1'b1; t++)
            step();
        chk("tick_vec", 32'(irq_vec_o), 32'h0);
        chk("tick_prio", 32'({irq_prio_o, irq_sub_o}), 32'h09);
        wr(VIP_OFF_FLAGS_LO, 32'h0);
        repeat (2) step();
        chk("tick_clr", 32'(irq_req_o), 32'h0);
        src_req_i[0] <= 1'b0;
        // priority zero is never forwarded
        fl = '{32'h1, 32'h0};
        pw[0] = 32'h0404_0400;
        load(32'h1);
        chk_win(1'b1, 32'h0, 32'h20);
        // level sources re-set, edge sources do not
        fl = '{32'h0, 32'h0};
        en = '{32'h3001_0000, 32'h0};
        load(32'h1);
        @(posedge mclk_i);
        src_req_i[31:0] <= 32'h3001_0000;
        repeat (3) step();
        wr(VIP_OFF_FLAGS_LO, 32'h0);
        rdchk("persist", VIP_OFF_FLAGS_LO, 32'h1001_0000);
        @(posedge mclk_i);
        src_req_i <= 64'h0;
        // pins with random polarity
        en = '{32'h0084_2108, 32'h0};
        for (int k = 0; k < 5; k++)
        begin
            // first pin always rising, so the pin edge assertion is reached
            m = (k == 0) ? 1'b1 : 1'($random(seed));
            @(posedge mclk_i);
            pin_i[k] <= ~m;
            load({26'h0, 5'(m) << k, 1'b1});
            @(posedge mclk_i);
            pin_i[k] <= m;
            for (int t = 0; t < 12 && taken !== 1'b1; t++)
                step();
            chk("pin_vec", 32'(taken_vec), 32'(PIN_VEC[k]));
            @(posedge mclk_i);
            pin_i[k] <= 1'b1;
        end
        // random contention, equal keys first
        for (int it = 0; it < 30; it++)
        begin
            fl[0] = $random(seed);
            fl[1] = $random(seed);
            en[0] = $random(seed);
            en[1] = $random(seed);
            for (int k = 0; k < 11; k++)
                pw[k] = (it < 2) ? 32'h1D1D_1D1D : $random(seed);
            base = $random(seed);
            sp = $random(seed) & 32'h3FF;
            m = it[0];
            wr(VIP_OFF_TBL_BASE, base);
            wr(VIP_OFF_TBL_SPACE, sp);
            load({31'h0, m});
            chk_win(m, base, sp);
        end
        complete_run();
    end
endmodule
